// ### logic/rlpc_top.sv
// Function
// R1: two ports, each with independent link settings
// R2: address range depends on selected protocol
// R3: out-of-range address means never reply
// R4: errors count only when running fully linked
// R5: mode 0 alarms and stops at once
// R6: mode 1 runs timer then always alarms
// R7: mode 2 alarms only without recovery in time
// R8: mode 3 keeps running, no alarm
// R9: error timer 0.0 to 60.0 s, 0.1 s
// R10: baud codes 0..3 give 2400..19200 bps
// R11: length code 0 eight bits, 1 seven
// R12: loader forces 8 bits, even, one stop
// R13: parity codes; Modbus stop bits follow parity
// R14: other protocols: stop code 0 two, 1 one
// R15: no-response time 1..60 s, 0 disables
// R16: wait response interval before reply starts
// R17: protocol codes; loader only on first port
// R18: start, data LSB first, parity, stop bits
`timescale 1ns/100ps
`include "rlpc_regs.svh"

module rlpc_top #(
  parameter int TICK_CYCLES = `RLPC_TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic             core_clk_i,
  input  wire logic             reset_n_i,
  // Wishbone slave.
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Drive state: one shared running flag, link commands per port.
  input  wire logic             drive_running_i,
  input  wire logic [1:0]       run_cmd_link_i,
  input  wire logic [1:0]       freq_cmd_link_i,
  // Link events from the character logic, per port.
  input  wire logic [1:0]       rx_done_i,
  input  wire logic [1:0]       rx_bcast_i,
  input  wire logic [1:0]       comm_error_i,
  // Effective framing, per port.
  output logic [1:0][15:0]      baud_div_o,
  output logic [1:0]            data_bits8_o,
  output logic [1:0]            parity_en_o,
  output logic [1:0]            parity_odd_o,
  output logic [1:0]            stop_two_o,
  // Addressing, per port.
  output logic [1:0][7:0]       station_address_o,
  output logic [1:0][7:0]       bcast_address_o,
  output logic [1:0]            bcast_en_o,
  output logic [1:0]            respond_en_o,
  // Reply timing and alarms per port; one shared stop request and interrupt.
  output logic [1:0]            reply_start_o,
  output logic [1:0]            alarm_o,
  output logic                  stop_request_o,
  output logic                  irq_o
);

  // ----------------------------------------------------------------
  // Constants.
  // ----------------------------------------------------------------
  localparam logic [19:0] TICK_LAST = 20'(TICK_CYCLES - 1);
  localparam logic [15:0] DIV0 = 16'(`RLPC_CLK_HZ / `RLPC_BAUD0);
  localparam logic [15:0] DIV1 = 16'(`RLPC_CLK_HZ / `RLPC_BAUD1);
  localparam logic [15:0] DIV2 = 16'(`RLPC_CLK_HZ / `RLPC_BAUD2);
  localparam logic [15:0] DIV3 = 16'(`RLPC_CLK_HZ / `RLPC_BAUD3);

  // ----------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic [31:0] rd_data;
  logic [31:0] wmask;
  logic [7:0]  status_reg, status_next, status_set, status_clr;
  logic [7:0]  mask_reg, mask_next;
  logic        irq_reg;
  logic [1:0]  alarm_clr_reg;
  logic [7:0]  state_word;
  logic [19:0] tick_cnt_reg;
  logic        tick_reg;
  wire         req, wr, rd_ok;
  wire         wr_status, wr_mask, wr_ctrl;

  assign req       = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr        = req & wb_we_i;
  assign wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wr_status = wr && (wb_adr_i == `RLPC_ADR_STATUS);
  assign wr_mask   = wr && (wb_adr_i == `RLPC_ADR_MASK);
  assign wr_ctrl   = wr && (wb_adr_i == `RLPC_ADR_CTRL);
  assign rd_ok     = req & ~wb_we_i;

  // ----------------------------------------------------------------
  // Per-port settings and decode.
  // ----------------------------------------------------------------
  logic [1:0][31:0] cfg_reg, time_reg;
  logic [1:0][7:0]  pev;
  logic [1:0]       respond_en_w, link_active_w, waiting_w, alarm_w;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      localparam logic [7:0] ADR_CFG  = (p == 0) ? `RLPC_ADR_P1_CFG : `RLPC_ADR_P2_CFG;
      localparam logic [7:0] ADR_TIME = (p == 0) ? `RLPC_ADR_P1_TIME : `RLPC_ADR_P2_TIME;
      logic [31:0]           cfg_next, time_next;
      logic [7:0]            addr;
      rlpc_pkg::rlpc_code_t  proto, baud, par, emode;
      logic [9:0]            etmr_raw, etmr;
      logic [5:0]            nrt_raw, nrt;
      logic [6:0]            ri_raw, ri;
      logic                  clen, stop, is_loader, is_modbus, addr_ok, proto_ok;
      logic [15:0]           div_w;
      logic                  bits8_w, par_en_w, par_odd_w, stop2_w, bc_en_w;
      logic [7:0]            bc_adr_w;
      logic                  err_evt, nr_evt, reply;

      // Writes obey the byte enables; unused upper bits stay zero.
      assign cfg_next  = (wr && wb_adr_i == ADR_CFG) ?
                         ((cfg_reg[p] & ~wmask) | (wb_dat_i & wmask)) & `RLPC_CFG_WMASK
                         : cfg_reg[p]; // R1
      assign time_next = (wr && wb_adr_i == ADR_TIME) ?
                         ((time_reg[p] & ~wmask) | (wb_dat_i & wmask)) & `RLPC_TIME_WMASK
                         : time_reg[p]; // R1

      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          cfg_reg[p]  <= `RLPC_CFG_RST;
          time_reg[p] <= `RLPC_TIME_RST;
        end else begin
          cfg_reg[p]  <= cfg_next;
          time_reg[p] <= time_next;
        end
      end

      assign addr  = cfg_reg[p][`RLPC_CFG_ADDR_LSB +: 8];
      assign emode = cfg_reg[p][`RLPC_CFG_EMODE_LSB +: 2];
      assign baud  = cfg_reg[p][`RLPC_CFG_BAUD_LSB +: 2];
      assign clen  = cfg_reg[p][`RLPC_CFG_CLEN_BIT];
      assign par   = cfg_reg[p][`RLPC_CFG_PAR_LSB +: 2];
      assign stop  = cfg_reg[p][`RLPC_CFG_STOP_BIT];
      assign proto = cfg_reg[p][`RLPC_CFG_PROTO_LSB +: 2];

      // Out-of-range entries saturate at the largest legal setting.
      assign etmr_raw = time_reg[p][`RLPC_TIME_ETMR_LSB +: 10];
      assign nrt_raw  = time_reg[p][`RLPC_TIME_NRT_LSB +: 6];
      assign ri_raw   = time_reg[p][`RLPC_TIME_RI_LSB +: 7];
      assign etmr = (etmr_raw > `RLPC_ETMR_MAX) ? `RLPC_ETMR_MAX : etmr_raw; // R9
      assign nrt  = (nrt_raw > `RLPC_NRT_MAX) ? `RLPC_NRT_MAX : nrt_raw; // R15
      assign ri   = (ri_raw > `RLPC_RI_MAX) ? `RLPC_RI_MAX : ri_raw; // R16

      assign is_loader = (proto == `RLPC_PROTO_LOADER);
      assign is_modbus = (proto == `RLPC_PROTO_MODBUS);
      assign proto_ok  = !(is_loader && p != 0); // R17

      assign addr_ok =
        is_modbus ? (addr != 8'h00 && addr <= `RLPC_MB_ADDR_MAX) :
        is_loader ? (addr != 8'h00 && addr <= `RLPC_LD_ADDR_MAX) :
        (proto == `RLPC_PROTO_GPINV) ? (addr != 8'h00 && addr <= `RLPC_GP_ADDR_MAX) :
        (addr != 8'h00); // R2
      assign bc_en_w  = is_modbus || (proto == `RLPC_PROTO_GPINV); // R2
      assign bc_adr_w = is_modbus ? `RLPC_MB_BCAST : `RLPC_GP_BCAST; // R2

      assign div_w = (baud == 2'h0) ? DIV0 :
                     (baud == 2'h1) ? DIV1 :
                     (baud == 2'h2) ? DIV2 : DIV3; // R10

      // The character logic shifts LSB first between start and stop.
      assign bits8_w   = is_loader | ~clen; // R11 R12 R18
      assign par_en_w  = is_loader | (par == `RLPC_PAR_EVEN) | (par == `RLPC_PAR_ODD); // R13
      assign par_odd_w = ~is_loader & (par == `RLPC_PAR_ODD); // R12 R13
      assign stop2_w   = is_loader ? 1'b0 :
                         is_modbus ? (par == 2'h0) : ~stop; // R12 R13 R14

      assign respond_en_w[p]  = addr_ok & proto_ok; // R3
      assign link_active_w[p] = drive_running_i & run_cmd_link_i[p]
                                & freq_cmd_link_i[p]; // R4

      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          baud_div_o[p]        <= DIV0;
          data_bits8_o[p]      <= 1'b1;
          parity_en_o[p]       <= 1'b0;
          parity_odd_o[p]      <= 1'b0;
          stop_two_o[p]        <= 1'b0;
          station_address_o[p] <= 8'h00;
          bcast_address_o[p]   <= 8'h00;
          bcast_en_o[p]        <= 1'b0;
          respond_en_o[p]      <= 1'b0;
        end else begin
          baud_div_o[p]        <= div_w;
          data_bits8_o[p]      <= bits8_w;
          parity_en_o[p]       <= par_en_w;
          parity_odd_o[p]      <= par_odd_w;
          stop_two_o[p]        <= stop2_w;
          station_address_o[p] <= addr;
          bcast_address_o[p]   <= bc_adr_w;
          bcast_en_o[p]        <= bc_en_w;
          respond_en_o[p]      <= respond_en_w[p];
        end
      end

      rlpc_port u_port (
        .core_clk_i    (core_clk_i),
        .reset_n_i     (reset_n_i),
        .tick_i        (tick_reg),
        .err_mode_i    (emode),
        .etmr_i        (etmr),
        .nrt_i         (nrt),
        .ri_i          (ri),
        .respond_en_i  (respond_en_w[p]),
        .link_active_i (link_active_w[p]),
        .rx_done_i     (rx_done_i[p]),
        .rx_bcast_i    (rx_bcast_i[p]),
        .comm_error_i  (comm_error_i[p]),
        .alarm_clr_i   (alarm_clr_reg[p]),
        .err_evt_o     (err_evt),
        .noresp_evt_o  (nr_evt),
        .reply_o       (reply),
        .alarm_o       (alarm_w[p]),
        .waiting_o     (waiting_w[p])
      );

      assign pev[p] = {4'h0, reply, nr_evt, alarm_w[p], err_evt};
    end
  endgenerate

  // ----------------------------------------------------------------
  // Time base.
  // ----------------------------------------------------------------
  // One shared tick keeps the long timers small at the cost of one
  // tick of jitter, which the reply interval count absorbs by counting one more.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tick_cnt_reg <= 20'h0_0000;
      tick_reg     <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TICK_LAST);
      if (tick_cnt_reg == TICK_LAST) begin
        tick_cnt_reg <= 20'h0_0000;
      end else begin
        tick_cnt_reg <= tick_cnt_reg + 20'h0_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask.
  // ----------------------------------------------------------------
  // Alarm status is a level copy of the port alarm, so it re-sets
  // while the alarm stands; events arriving in a clear cycle win.
  assign status_set  = {pev[1][3:0], pev[0][3:0]};
  assign status_clr  = wr_status ? (wb_dat_i[7:0] & wmask[7:0]) : 8'h00;
  assign status_next = (status_reg & ~status_clr) | status_set;
  assign mask_next   = wr_mask ? ((mask_reg & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]))
                       : mask_reg;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      status_reg    <= 8'h00;
      mask_reg      <= 8'h00;
      irq_reg       <= 1'b0;
      alarm_clr_reg <= 2'h0;
    end else begin
      status_reg    <= status_next;
      mask_reg      <= mask_next;
      irq_reg       <= |(status_next & mask_next);
      alarm_clr_reg <= wr_ctrl ? (wb_dat_i[1:0] & wmask[1:0]) : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // Read path and acknowledge.
  // ----------------------------------------------------------------
  assign state_word = {waiting_w, link_active_w, respond_en_w, alarm_w};

  assign rd_data =
    (wb_adr_i == `RLPC_ADR_P1_CFG)  ? cfg_reg[0]  :
    (wb_adr_i == `RLPC_ADR_P1_TIME) ? time_reg[0] :
    (wb_adr_i == `RLPC_ADR_P2_CFG)  ? cfg_reg[1]  :
    (wb_adr_i == `RLPC_ADR_P2_TIME) ? time_reg[1] :
    (wb_adr_i == `RLPC_ADR_STATUS)  ? {24'h00_0000, status_reg} :
    (wb_adr_i == `RLPC_ADR_MASK)    ? {24'h00_0000, mask_reg} :
    (wb_adr_i == `RLPC_ADR_STATE)   ? {24'h00_0000, state_word} :
    32'h0000_0000;

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req;
      if (rd_ok) begin
        dat_reg <= rd_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      reply_start_o  <= 2'h0;
      alarm_o        <= 2'h0;
      stop_request_o <= 1'b0;
    end else begin
      reply_start_o  <= {pev[1][3], pev[0][3]}; // R16
      alarm_o        <= alarm_w; // R5 R6 R7
      stop_request_o <= |alarm_w; // R5
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign irq_o    = irq_reg;

endmodule

// ### logic/rlpc_regs.svh
`ifndef RLPC_REGS_SVH
`define RLPC_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define RLPC_ADR_P1_CFG   8'h00
`define RLPC_ADR_P1_TIME  8'h04
`define RLPC_ADR_P2_CFG   8'h08
`define RLPC_ADR_P2_TIME  8'h0C
`define RLPC_ADR_STATUS   8'h10
`define RLPC_ADR_MASK     8'h14
`define RLPC_ADR_CTRL     8'h18
`define RLPC_ADR_STATE    8'h1C
// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define RLPC_CFG_ADDR_LSB  0
`define RLPC_CFG_EMODE_LSB 8
`define RLPC_CFG_BAUD_LSB  10
`define RLPC_CFG_CLEN_BIT  12
`define RLPC_CFG_PAR_LSB   13
`define RLPC_CFG_STOP_BIT  15
`define RLPC_CFG_PROTO_LSB 16
`define RLPC_TIME_ETMR_LSB 0
`define RLPC_TIME_NRT_LSB  10
`define RLPC_TIME_RI_LSB   16
// ----------------------------------------------------------------
// Reset values and write masks.
// ----------------------------------------------------------------
`define RLPC_CFG_RST   32'h0000_8001
`define RLPC_TIME_RST  32'h0000_0000
`define RLPC_CFG_WMASK 32'h0003_FFFF
`define RLPC_TIME_WMASK 32'h007F_FFFF
// ----------------------------------------------------------------
// Protocol, mode and setting codes.
// ----------------------------------------------------------------
`define RLPC_PROTO_MODBUS 2'h0
`define RLPC_PROTO_LOADER 2'h1
`define RLPC_PROTO_GPINV  2'h2
`define RLPC_PROTO_BAS    2'h3
`define RLPC_EMODE_STOP   2'h0
`define RLPC_EMODE_TIMED  2'h1
`define RLPC_EMODE_RECOV  2'h2
`define RLPC_EMODE_RUN    2'h3
`define RLPC_PAR_EVEN     2'h1
`define RLPC_PAR_ODD      2'h2
`define RLPC_MB_ADDR_MAX  8'hF7
`define RLPC_LD_ADDR_MAX  8'hFF
`define RLPC_GP_ADDR_MAX  8'h1F
`define RLPC_MB_BCAST     8'h00
`define RLPC_GP_BCAST     8'h63

// ----------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------
`define RLPC_CLK_HZ       100000000
`define RLPC_TICK_MS      10
`define RLPC_TICK_CYCLES  (`RLPC_CLK_HZ / 1000 * `RLPC_TICK_MS)
`define RLPC_ETMR_UNIT_MS 100
`define RLPC_NRT_UNIT_MS  1000
`define RLPC_ETMR_TICKS   (`RLPC_ETMR_UNIT_MS / `RLPC_TICK_MS)
`define RLPC_NRT_TICKS    (`RLPC_NRT_UNIT_MS / `RLPC_TICK_MS)
`define RLPC_ETMR_MAX     10'h258
`define RLPC_NRT_MAX      6'h3C
`define RLPC_RI_MAX       7'h64
`define RLPC_BAUD0        2400
`define RLPC_BAUD1        4800
`define RLPC_BAUD2        9600
`define RLPC_BAUD3        19200

`endif

// ### logic/rlpc_pkg.sv
package rlpc_pkg;

  typedef enum {
    ERR_IDLE,
    ERR_WAIT,
    ERR_ALARM
  } rlpc_err_state_t;

  typedef logic [1:0] rlpc_code_t;

endpackage

// ### logic/rlpc_port.sv
`timescale 1ns/100ps
`include "rlpc_regs.svh"

module rlpc_port (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // Settings and time base.
  input  wire logic        tick_i,
  input  wire logic [1:0]  err_mode_i,
  input  wire logic [9:0]  etmr_i,
  input  wire logic [5:0]  nrt_i,
  input  wire logic [6:0]  ri_i,
  input  wire logic        respond_en_i,
  // Link state and events, and the alarm clear.
  input  wire logic        link_active_i,
  input  wire logic        rx_done_i,
  input  wire logic        rx_bcast_i,
  input  wire logic        comm_error_i,
  input  wire logic        alarm_clr_i,
  // Results.
  output logic             err_evt_o,
  output logic             noresp_evt_o,
  output logic             reply_o,
  output logic             alarm_o,
  output logic             waiting_o
);

  // ----------------------------------------------------------------
  // Counters.
  // ----------------------------------------------------------------
  rlpc_pkg::rlpc_err_state_t state_reg, state_next;
  logic [12:0] nr_cnt_reg, wt_cnt_reg, nr_limit, wt_limit;
  logic [7:0]  ri_cnt_reg, ri_target;
  logic        ri_busy_reg;
  wire         nr_to, err_evt, recovered, ri_done, ri_start, wt_done;

  assign nr_limit  = 13'(nrt_i * `RLPC_NRT_TICKS);
  assign wt_limit  = 13'(etmr_i * `RLPC_ETMR_TICKS);
  assign nr_to     = (nrt_i != 6'h00) && (nr_cnt_reg >= nr_limit); // R15
  assign err_evt   = (comm_error_i | nr_to) & link_active_i; // R4
  assign recovered = rx_done_i & ~comm_error_i;
  assign wt_done   = wt_cnt_reg >= wt_limit;
  assign ri_target = {1'b0, ri_i} + 8'h01;
  assign ri_start  = rx_done_i & ~comm_error_i & ~rx_bcast_i & respond_en_i; // R3
  assign ri_done   = ri_busy_reg && ((ri_i == 7'h00) || (ri_cnt_reg >= ri_target)); // R16

  // ----------------------------------------------------------------
  // Error handling state machine.
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      rlpc_pkg::ERR_IDLE: begin
        if (err_evt) begin
          case (err_mode_i)
            `RLPC_EMODE_STOP:  state_next = rlpc_pkg::ERR_ALARM; // R5
            `RLPC_EMODE_TIMED: state_next = rlpc_pkg::ERR_WAIT; // R6
            `RLPC_EMODE_RECOV: state_next = rlpc_pkg::ERR_WAIT; // R7
            default:           state_next = rlpc_pkg::ERR_IDLE; // R8
          endcase
        end
      end
      rlpc_pkg::ERR_WAIT: begin
        if (wt_done) begin
          state_next = rlpc_pkg::ERR_ALARM; // R6
        end else if (recovered && err_mode_i == `RLPC_EMODE_RECOV) begin
          state_next = rlpc_pkg::ERR_IDLE; // R7
        end else if (err_mode_i == `RLPC_EMODE_RUN) begin
          state_next = rlpc_pkg::ERR_IDLE; // R8
        end
      end
      rlpc_pkg::ERR_ALARM: begin
        if (alarm_clr_i) begin
          state_next = rlpc_pkg::ERR_IDLE;
        end
      end
      default: state_next = rlpc_pkg::ERR_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers.
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      state_reg <= rlpc_pkg::ERR_IDLE;
      wt_cnt_reg <= 13'h0000;
    end else begin
      state_reg <= state_next;
      if (state_reg != rlpc_pkg::ERR_WAIT) begin
        wt_cnt_reg <= 13'h0000;
      end else if (tick_i) begin
        wt_cnt_reg <= wt_cnt_reg + 13'h0001; // R9
      end
    end
  end

  // Any access restarts the silence count, even a broadcast one.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      nr_cnt_reg <= 13'h0000;
    end else if (rx_done_i || nr_to) begin
      nr_cnt_reg <= 13'h0000;
    end else if (tick_i) begin
      nr_cnt_reg <= nr_cnt_reg + 13'h0001; // R15
    end
  end

  // The extra tick guards the minimum, as the tick phase is unknown.
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ri_busy_reg <= 1'b0;
      ri_cnt_reg  <= 8'h00;
    end else if (ri_start) begin
      ri_busy_reg <= 1'b1;
      ri_cnt_reg  <= 8'h00;
    end else if (ri_done) begin
      ri_busy_reg <= 1'b0;
    end else if (tick_i && ri_busy_reg) begin
      ri_cnt_reg <= ri_cnt_reg + 8'h01;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      err_evt_o    <= 1'b0;
      noresp_evt_o <= 1'b0;
      reply_o      <= 1'b0;
      alarm_o      <= 1'b0;
      waiting_o    <= 1'b0;
    end else begin
      err_evt_o    <= err_evt;
      noresp_evt_o <= nr_to & link_active_i;
      reply_o      <= ri_done & ~ri_start;
      alarm_o      <= state_next == rlpc_pkg::ERR_ALARM;
      waiting_o    <= state_next == rlpc_pkg::ERR_WAIT;
    end
  end

endmodule

// ### verif/rlpc_monitor.sv
`timescale 1ns/100ps
module rlpc_monitor (
  // Clock and reset.
  input wire logic            core_clk_i,
  input wire logic            reset_n_i,
  // Bus handshake.
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o,
  // Framing and addressing.
  input wire logic [1:0]      parity_en_o,
  input wire logic [1:0]      parity_odd_o,
  input wire logic [1:0]      stop_two_o,
  input wire logic [1:0][7:0] station_address_o,
  input wire logic [1:0][7:0] bcast_address_o,
  input wire logic [1:0]      bcast_en_o,
  input wire logic [1:0]      respond_en_o,
  // Supervision.
  input wire logic [1:0]      reply_start_o,
  input wire logic [1:0]      alarm_o,
  input wire logic            stop_request_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_alarm; $rose(alarm_o[0]); endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_odd_needs_parity: assert property ((parity_odd_o & ~parity_en_o) == 2'h0)
    else $error("odd parity without parity bit");
  a_rtu_stop_bits: assert property (bcast_en_o[0] && bcast_address_o[0] == 8'h00
    && parity_en_o[0] |-> !stop_two_o[0]) else $error("stop bits not one with parity");
  a_addr_nonzero: assert property (respond_en_o[0] |-> station_address_o[0] != 8'h00)
    else $error("reply enabled at address zero");
  a_bcast_code: assert property (bcast_en_o[0] |-> bcast_address_o[0] inside {8'h00, 8'h63})
    else $error("bad broadcast address");
  a_alarm_stops: assert property (s_alarm |-> ##[0:1] stop_request_o)
    else $error("alarm without stop");
  a_reply_single: assert property (reply_start_o[0] |=> !reply_start_o[0])
    else $error("reply start longer than a pulse");
endmodule
bind rlpc_top rlpc_monitor u_mon (.*);

// ### verif/rlpc_host.sv
`timescale 1ns/100ps
module rlpc_host (
  // Clock.
  input  wire logic       core_clk_i,
  // Commands from the bench.
  input  wire logic [1:0] send_i,
  input  wire logic       bad_i,
  input  wire logic       bcast_i,
  // Link events.
  output logic      [1:0] rx_done_o,
  output logic      [1:0] rx_bcast_o,
  output logic      [1:0] comm_error_o
);
  // A polled request arrives whole or fails whole; the bench sets the pace of polling.
  always_ff @(posedge core_clk_i) begin
    rx_done_o    <= send_i & ~{2{bad_i}};
    rx_bcast_o   <= send_i & {2{bcast_i}};
    comm_error_o <= send_i & {2{bad_i}};
  end
endmodule

// ### verif/rlpc_tb_top.sv
`timescale 1ns/100ps
module rlpc_tb_top;
  logic             clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic             run = 1'b0, bad = 1'b0, bc = 1'b0, ack, stop, irq;
  logic [7:0]       adr = 8'h00;
  logic [31:0]      dat = 32'h0000_0000, rd, wdo;
  logic [1:0]       rl = 2'h0, fl = 2'h0, send = 2'h0, done, bcs, cerr;
  logic [1:0]       d8, pen, podd, st2, bce, ren, rep, alm;
  logic [1:0][7:0]  bca;
  logic [1:0][15:0] baud;
  logic [2:0]       q3, q4;
  logic [15:0]      divs [4] = '{16'hA2C2, 16'h5161, 16'h28B0, 16'h1458};
  int               errors = 0, n_compared = 0, cyc_n = 0;
  always #5 clk = ~clk;
  rlpc_host host (.core_clk_i(clk), .send_i(send), .bad_i(bad), .bcast_i(bc),
    .rx_done_o(done), .rx_bcast_o(bcs), .comm_error_o(cerr));
  rlpc_top #(.TICK_CYCLES(20)) dut (.core_clk_i(clk), .reset_n_i(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_dat_o(wdo), .wb_ack_o(ack), .drive_running_i(run), .run_cmd_link_i(rl),
    .freq_cmd_link_i(fl), .rx_done_i(done), .rx_bcast_i(bcs), .comm_error_i(cerr),
    .baud_div_o(baud), .data_bits8_o(d8), .parity_en_o(pen), .parity_odd_o(podd),
    .stop_two_o(st2), .station_address_o(), .bcast_address_o(bca), .bcast_en_o(bce),
    .respond_en_o(ren), .reply_start_o(rep), .alarm_o(alm), .stop_request_o(stop), .irq_o(irq));
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, e, s);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = wdo;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk);
  endtask
  function automatic logic [31:0] cw(logic [1:0] pr, logic sp, logic [1:0] pa, logic cl,
      logic [1:0] bd, logic [1:0] md, logic [7:0] ad);
    return {14'h0000, pr, sp, pa, cl, bd, md, ad};
  endfunction
  task automatic fire(input logic b, input logic c);
    send <= 2'h1; bad <= b; bc <= c;
    @(posedge clk);
    send <= 2'h0;
    repeat (2) @(posedge clk);
    q3 = {rep[0], alm[0], irq};
    repeat (2) @(posedge clk);
    q4 = {rep[0], alm[0], irq};
  endtask
  task automatic t_regs;
    wb(1'b0, 8'h00, 32'h0000_0000); chk("cfg1", rd, 32'h0000_8001);
    wb(1'b0, 8'h20, 32'h0000_0000); chk("unmapped", rd, 32'h0000_0000);
    chk("respond", ren, 2'h3);
  endtask
  task automatic t_baud;
    for (int b = 0; b < 4; b++) begin
      wb(1'b1, 8'h00, cw(2'h0, 1'b1, 2'h1, 1'b0, b[1:0], 2'h0, 8'h01));
      chk("baud1", baud[0], divs[b]);
      chk("baud2", baud[1], 16'hA2C2);
    end
  endtask
  task automatic acfg(input logic [1:0] pr, input logic [7:0] ad, input logic e);
    wb(1'b1, 8'h00, cw(pr, 1'b1, 2'h1, 1'b0, 2'h2, 2'h0, ad));
    chk("respond1", ren[0], e);
  endtask
  task automatic t_addr;
    acfg(2'h0, 8'hF7, 1'b1); acfg(2'h0, 8'hF8, 1'b0); acfg(2'h0, 8'h00, 1'b0);
    acfg(2'h3, 8'hFF, 1'b1); acfg(2'h3, 8'h00, 1'b0);
    acfg(2'h1, 8'hFF, 1'b1); acfg(2'h2, 8'h20, 1'b0); acfg(2'h2, 8'h1F, 1'b1);
    chk("bcast", {bce[0], bca[0]}, 9'h163);
    wb(1'b1, 8'h08, cw(2'h1, 1'b1, 2'h1, 1'b0, 2'h2, 2'h0, 8'h05));
    chk("loader2", ren[1], 1'b0);
  endtask
  task automatic fcfg(input logic [1:0] pr, input logic sp, input logic [1:0] pa,
      input logic cl, input logic [3:0] e);
    wb(1'b1, 8'h00, cw(pr, sp, pa, cl, 2'h2, 2'h0, 8'h01));
    chk("frame", {d8[0], pen[0], podd[0], st2[0]}, e);
  endtask
  task automatic t_frame;
    fcfg(2'h1, 1'b0, 2'h0, 1'b1, 4'hC); fcfg(2'h0, 1'b1, 2'h0, 1'b0, 4'h9);
    fcfg(2'h0, 1'b0, 2'h2, 1'b0, 4'hE); fcfg(2'h0, 1'b0, 2'h3, 1'b0, 4'h8);
    fcfg(2'h2, 1'b0, 2'h3, 1'b1, 4'h1); fcfg(2'h2, 1'b1, 2'h1, 1'b0, 4'hC);
  endtask
  task automatic t_reply;
    wb(1'b1, 8'h00, cw(2'h0, 1'b1, 2'h1, 1'b0, 2'h2, 2'h0, 8'h01));
    wb(1'b1, 8'h14, 32'h0000_0008);
    fire(1'b0, 1'b0); chk("reply", {q3[2], q4[2], q4[0]}, 3'h3);
    wb(1'b1, 8'h10, 32'h0000_0008); chk("irq", irq, 1'b0);
    fire(1'b0, 1'b1); chk("bcast reply", q4[2], 1'b0);
    wb(1'b1, 8'h00, cw(2'h0, 1'b1, 2'h1, 1'b0, 2'h2, 2'h0, 8'hF8));
    fire(1'b0, 1'b0); chk("bad addr", q4[2], 1'b0);
  endtask
  task automatic mode(input logic [1:0] m);
    wb(1'b1, 8'h00, cw(2'h0, 1'b1, 2'h1, 1'b0, 2'h2, m, 8'h01));
    wb(1'b1, 8'h18, 32'h0000_0001);
    repeat (3) @(posedge clk);
  endtask
  task automatic t_alarm;
    run <= 1'b1; rl <= 2'h1;
    mode(2'h0); fire(1'b1, 1'b0); chk("unlinked", q4[1], 1'b0);
    fl <= 2'h1;
    fire(1'b1, 1'b0); chk("mode0", {q3[1], q4[1], stop}, 3'h3);
    mode(2'h3); fire(1'b1, 1'b0); repeat (300) @(posedge clk); chk("mode3", alm[0], 1'b0);
    wb(1'b1, 8'h04, 32'h0000_0001);
    mode(2'h1); fire(1'b1, 1'b0); chk("mode1 wait", q4[1], 1'b0);
    fire(1'b0, 1'b0); repeat (300) @(posedge clk); chk("mode1", alm[0], 1'b1);
    mode(2'h2); fire(1'b1, 1'b0); fire(1'b0, 1'b0);
    repeat (300) @(posedge clk); chk("mode2", alm[0], 1'b0);
    wb(1'b1, 8'h04, 32'h0000_0400);
    repeat (2100) @(posedge clk); chk("noresp", alm[0], 1'b1);
  endtask
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      errors++;
      print_verdict;
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs; t_baud; t_addr; t_frame; t_reply; t_alarm;
    print_verdict;
  end
endmodule
